// File: shared/sscl_pkg.sv
// Constants shared by the serial setup chain loader
package sscl_pkg;
	localparam int SSCL_SETUP_BITS = 64;
	localparam logic SSCL_DONE_IDLE = 1'h1;
	localparam logic SSCL_PASS_IDLE = 1'h0;
	localparam logic SSCL_ENABLE_ACTIVE = 1'h0;
	typedef enum logic {
		SSCL_MODE_DEFAULT,
		SSCL_MODE_SERIAL
	} sscl_mode_e;
endpackage : sscl_pkg

// File: shared/sscl_link_if.sv
// Signals between the loader control and its serial clock domain shifter
`timescale 1ns/1ps
interface sscl_link_if #(parameter int BITS = 64);
	logic sclk;
	logic arm;
	logic si;
	logic en_n;
	logic [BITS-1:0] setup;
	logic loaded;
	modport shifter (input sclk, input arm, input si, input en_n, output setup, output loaded);
	modport ctrl (output sclk, output arm, output si, output en_n, input setup, input loaded);
endinterface : sscl_link_if

// File: hdl/sscl_shifter.sv
// Setup shift register clocked by the serial configuration clock
`timescale 1ns/1ps
module sscl_shifter import sscl_pkg::*; #(
	parameter int BITS = SSCL_SETUP_BITS
) (
	sscl_link_if.shifter lnk // Serial clock side of the link
);
	logic arm_meta;
	logic arm_sync;
	logic [$clog2(BITS+1)-1:0] cnt;
	logic [BITS-1:0] shift;
	logic loaded;

	// ****************************************
	// Arm crossing from core clock
	// ****************************************
	always_ff @(posedge lnk.sclk) begin
		arm_meta <= lnk.arm;
		arm_sync <= arm_meta;
	end

	// ****************************************
	// Shift and load tracking
	// ****************************************
	always_ff @(posedge lnk.sclk) begin
		if (!arm_sync) begin
			cnt <= '0;
			loaded <= 1'b0;
		end else if (lnk.en_n == SSCL_ENABLE_ACTIVE && !loaded) begin
			cnt <= cnt + 1'b1;
			loaded <= (cnt == ($clog2(BITS+1))'(BITS - 1));
		end
	end

	// Cleared while disarmed so a new load never starts from stale bits
	always_ff @(posedge lnk.sclk) begin
		if (!arm_sync) begin
			shift <= '0;
		end else if (lnk.en_n == SSCL_ENABLE_ACTIVE && !loaded) begin
			shift <= {shift[BITS-2:0], lnk.si};
		end
	end

	assign lnk.setup = shift;
	assign lnk.loaded = loaded;

	// ****************************************
	// Checks
	// ****************************************
	property p_hold_when_disabled;
		@(posedge lnk.sclk) disable iff (!arm_sync)
		lnk.en_n |=> $stable(shift);
	endproperty
	a_hold_when_disabled: assert property (p_hold_when_disabled)
		else $error("setup shifted while chain enable high");

	property p_shift_in;
		@(posedge lnk.sclk) disable iff (!arm_sync)
		(!lnk.en_n && !loaded) |=> shift == {$past(shift[BITS-2:0]), $past(lnk.si)};
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("serial bit not captured into setup register");

	property p_loaded_sticks;
		@(posedge lnk.sclk) disable iff (!arm_sync)
		loaded |=> loaded && $stable(shift);
	endproperty
	a_loaded_sticks: assert property (p_loaded_sticks)
		else $error("setup changed after full load");
endmodule : sscl_shifter

// File: hdl/sscl_loader.sv
// Serial setup chain loader, core clock side and pin logic
//
// What this block does
// - Serial clock shifts setup only when serial mode chosen at master reset.
// - Serial clock rises capture serial input while chain enable is low, until all setup bits are loaded.
// - Chain done reports finished configuration, serial or default.
// - Once configured, chain done follows chain enable input.
// - Chain done low means queue reads and writes may start.
// - Configured chain done drives next device enable low to start it.
// - When loaded and done low, serial input passes to serial pass output.
// - Setup registers are shift registers filled from serial input.
`timescale 1ns/1ps
module sscl_loader import sscl_pkg::*; #(
	parameter int BITS = SSCL_SETUP_BITS
) (
	input wire logic clk, // Core clock, 250 MHz
	input wire logic srst, // Master reset, synchronous, active high
	input wire logic serial_mode_sel, // Strap: high selects serial programming
	input wire logic sclk, // Serial configuration clock
	input wire logic serial_in, // Serial configuration data
	input wire logic chain_enable_in_n, // Chain enable, active low
	output logic chain_done_out_n, // Chain done, active low
	output logic serial_pass_out, // Serial data to next device
	output logic queue_ready, // Queue operations allowed
	output logic configured, // Setup complete
	output logic [BITS-1:0] setup_data // Setup register contents
);
	sscl_link_if #(.BITS(BITS)) lnk ();

	sscl_mode_e mode;
	logic sel_meta;
	logic sel_sync;
	logic en_meta;
	logic en_sync;
	logic si_meta;
	logic si_sync;
	logic ld_meta;
	logic ld_sync;
	logic ld_seen;
	logic ld_clear;
	logic arm;

	// ****************************************
	// Link to serial clock domain
	// ****************************************
	assign lnk.sclk = sclk;
	assign lnk.arm = arm;
	assign lnk.si = serial_in;
	assign lnk.en_n = chain_enable_in_n;

	sscl_shifter #(.BITS(BITS)) u_shifter (
		.lnk(lnk.shifter)
	);

	// ****************************************
	// Pin and load flag synchronisers
	// ****************************************
	always_ff @(posedge clk) begin
		sel_meta <= serial_mode_sel;
		sel_sync <= sel_meta;
		en_meta <= chain_enable_in_n;
		en_sync <= en_meta;
		si_meta <= serial_in;
		si_sync <= si_meta;
		ld_meta <= lnk.loaded;
		ld_sync <= ld_meta;
	end

	// ****************************************
	// Mode capture at master reset
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			mode <= sel_sync ? SSCL_MODE_SERIAL : SSCL_MODE_DEFAULT;
		end
	end

	// Shifter stays cleared through reset and in default mode
	always_ff @(posedge clk) begin
		if (srst) begin
			arm <= 1'b0;
		end else begin
			arm <= (mode == SSCL_MODE_SERIAL);
		end
	end

	// ****************************************
	// Completion tracking
	// ****************************************
	// Stale load flag from before reset must drop before a load counts
	always_ff @(posedge clk) begin
		if (srst) begin
			ld_clear <= 1'h0;
		end else if (arm && !ld_sync) begin
			ld_clear <= 1'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ld_seen <= 1'h0;
		end else begin
			ld_seen <= ld_sync && arm && ld_clear;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			configured <= 1'b0;
		end else if (mode == SSCL_MODE_DEFAULT) begin
			configured <= 1'b1;
		end else begin
			configured <= ld_seen;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			setup_data <= '0;
		end else if (mode == SSCL_MODE_SERIAL && ld_seen && !configured) begin
			setup_data <= lnk.setup; // quasi-static once loaded
		end
	end

	// ****************************************
	// Chain outputs
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst || !configured) begin
			chain_done_out_n <= SSCL_DONE_IDLE;
			queue_ready <= 1'b0;
		end else begin
			chain_done_out_n <= en_sync;
			queue_ready <= !en_sync;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || !configured || en_sync) begin
			serial_pass_out <= SSCL_PASS_IDLE;
		end else begin
			serial_pass_out <= si_sync;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_idle_until_configured;
		@(posedge clk) disable iff (srst)
		!configured |=> $past(!configured) && chain_done_out_n && !queue_ready;
	endproperty
	a_idle_until_configured: assert property (p_idle_until_configured)
		else $error("chain done active before configuration");

	property p_follow_enable;
		@(posedge clk) disable iff (srst)
		configured |=> chain_done_out_n == $past(en_sync);
	endproperty
	a_follow_enable: assert property (p_follow_enable)
		else $error("chain done does not follow chain enable");

	property p_ready_with_done;
		@(posedge clk) disable iff (srst)
		queue_ready == (!chain_done_out_n);
	endproperty
	a_ready_with_done: assert property (p_ready_with_done)
		else $error("queue ready disagrees with chain done");

	property p_pass_through;
		@(posedge clk) disable iff (srst)
		(configured && !en_sync) |=> serial_pass_out == $past(si_sync);
	endproperty
	a_pass_through: assert property (p_pass_through)
		else $error("serial data not passed to next device");

	property p_default_completes;
		@(posedge clk) disable iff (srst)
		(mode == SSCL_MODE_DEFAULT) |=> configured;
	endproperty
	a_default_completes: assert property (p_default_completes)
		else $error("default programming did not complete");

	property p_serial_waits_load;
		@(posedge clk) disable iff (srst)
		(mode == SSCL_MODE_SERIAL && !ld_sync) |=> ##1 !configured || $past(configured, 2);
	endproperty
	a_serial_waits_load: assert property (p_serial_waits_load)
		else $error("serial mode configured without a full load");

	property p_cascade_start;
		@(posedge clk) disable iff (srst)
		(configured && !en_sync) |=> !chain_done_out_n;
	endproperty
	a_cascade_start: assert property (p_cascade_start)
		else $error("next device not enabled after configuration");

	property p_configured_sticks;
		@(posedge clk) disable iff (srst)
		configured |=> configured;
	endproperty
	a_configured_sticks: assert property (p_configured_sticks)
		else $error("configuration dropped without master reset");

	property p_setup_capture;
		@(posedge clk) disable iff (srst)
		(mode == SSCL_MODE_SERIAL && ld_seen && !configured) |=> setup_data == $past(lnk.setup);
	endproperty
	a_setup_capture: assert property (p_setup_capture)
		else $error("loaded setup not captured");

	property p_done_release;
		@(posedge clk) disable iff (srst)
		(configured && en_sync) |=> chain_done_out_n;
	endproperty
	a_done_release: assert property (p_done_release)
		else $error("chain done stays low with chain enable high");

	property p_pass_idle;
		@(posedge clk) disable iff (srst)
		(!configured || en_sync) |=> serial_pass_out == SSCL_PASS_IDLE;
	endproperty
	a_pass_idle: assert property (p_pass_idle)
		else $error("serial data passed on while not enabled");
endmodule : sscl_loader

// File: tb/sscl_host_model.sv
// Host model driving the serial setup chain of one device
`timescale 1ns/1ps
module sscl_host_model #(
	parameter realtime HALF = 62.5
) (
	output logic sclk, // Serial clock, still outside frames
	output logic serial_in, // Serial data
	output logic chain_enable_in_n // Chain enable, active low
);
	initial begin
		sclk = 1'h0;
		serial_in = 1'h0;
		chain_enable_in_n = 1'h1;
	end
	// Host owns the enable of the single device
	task set_en(input logic v);
		chain_enable_in_n = v;
	endtask : set_en
	task drive_si(input logic v);
		serial_in = v;
	endtask : drive_si
	// Eight bits MSB first from one clock source
	task frame(input logic [7:0] bits);
		#1.3;
		for (int i = 7; i >= 0; i--) begin
			serial_in = bits[i];
			#HALF sclk = 1'h1;
			#HALF sclk = 1'h0;
		end
		serial_in = ~bits[0];
	endtask : frame
endmodule : sscl_host_model

// File: tb/sscl_loader_test.sv
// Self-checking bench for the serial setup chain loader
`timescale 1ns/1ps
module sscl_loader_test import sscl_pkg::*;;
	localparam int BITS = 8;
	logic clk, srst, serial_mode_sel, sclk, serial_in, chain_enable_in_n;
	logic chain_done_out_n, serial_pass_out, queue_ready, configured;
	logic [BITS-1:0] setup_data;
	int n_fail = 0;
	int compares = 0;
	sscl_loader #(.BITS(BITS)) sscl_loader_inst (.clk(clk), .srst(srst),
		.serial_mode_sel(serial_mode_sel), .sclk(sclk), .serial_in(serial_in),
		.chain_enable_in_n(chain_enable_in_n), .chain_done_out_n(chain_done_out_n),
		.serial_pass_out(serial_pass_out), .queue_ready(queue_ready),
		.configured(configured), .setup_data(setup_data));
	sscl_host_model sscl_host_model_inst (.sclk(sclk), .serial_in(serial_in),
		.chain_enable_in_n(chain_enable_in_n));
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	task chk(input string name, input logic [BITS-1:0] seen, input logic [BITS-1:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task do_reset(input logic mode);
		cyc(1);
		srst = 1'h1;
		serial_mode_sel = mode;
		cyc(12);
		srst = 1'h0;
	endtask : do_reset
	task t_default;
		sscl_host_model_inst.set_en(1'h1);
		do_reset(SSCL_MODE_DEFAULT);
		cyc(1);
		chk("done_reset", chain_done_out_n, SSCL_DONE_IDLE);
		cyc(6);
		chk("configured", configured, 1'h1);
		chk("done_en_high", chain_done_out_n, 1'h1);
		sscl_host_model_inst.set_en(1'h0);
		sscl_host_model_inst.frame(8'hA5);
		chk("setup_default", setup_data, '0);
		chk("done_en_low", chain_done_out_n, 1'h0);
		chk("ready", queue_ready, 1'h1);
		sscl_host_model_inst.set_en(1'h1);
		cyc(6);
		chk("done_back", chain_done_out_n, 1'h1);
		chk("ready_off", queue_ready, 1'h0);
		$display("test default done");
	endtask : t_default
	task t_serial;
		sscl_host_model_inst.set_en(1'h1);
		do_reset(SSCL_MODE_SERIAL);
		cyc(3);
		sscl_host_model_inst.frame(8'h3C);
		sscl_host_model_inst.frame(8'h3C);
		cyc(8);
		chk("setup_hold", setup_data, '0);
		chk("not_cfg", configured, 1'h0);
		chk("done_hold", chain_done_out_n, SSCL_DONE_IDLE);
		sscl_host_model_inst.set_en(1'h0);
		sscl_host_model_inst.frame(8'hB2);
		for (int i = 0; i < 20 && chain_done_out_n !== 1'h0; i++) cyc(1);
		chk("setup_load", setup_data, 8'hB2);
		chk("cfg", configured, 1'h1);
		chk("done_low", chain_done_out_n, 1'h0);
		chk("ready_on", queue_ready, 1'h1);
		sscl_host_model_inst.frame(8'h0F);
		chk("setup_kept", setup_data, 8'hB2);
		for (int v = 1; v >= 0; v--) begin
			sscl_host_model_inst.drive_si(v[0]);
			cyc(6);
			chk("pass", serial_pass_out, v[0]);
		end
		sscl_host_model_inst.drive_si(1'h1);
		sscl_host_model_inst.set_en(1'h1);
		cyc(6);
		chk("done_off", chain_done_out_n, 1'h1);
		chk("pass_off", serial_pass_out, SSCL_PASS_IDLE);
		$display("test serial done");
	endtask : t_serial
	task final_report;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	initial begin
		srst = 1'h1;
		serial_mode_sel = 1'h0;
		t_default();
		t_serial();
		final_report();
	end
	initial begin
		#20000;
		n_fail++;
		final_report();
	end
endmodule : sscl_loader_test
